/* File: dpg_pkg.sv */
// shared constants and types of the dual gpio port block
package dpg_pkg;

   // ********************************
   // widths
   // ********************************
   localparam int unsigned PORT_W = 8;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PAD_W  = DATA_W - PORT_W;

   typedef logic [PORT_W-1:0] dpg_byte_t;
   typedef logic [ADDR_W-1:0] dpg_addr_t;

   // ********************************
   // register byte addresses
   // ********************************
   localparam dpg_addr_t OFS_C_PINS = 5'h00;
   localparam dpg_addr_t OFS_C_LAT  = 5'h04;
   localparam dpg_addr_t OFS_C_DIR  = 5'h08;
   localparam dpg_addr_t OFS_D_PINS = 5'h0c;
   localparam dpg_addr_t OFS_D_LAT  = 5'h10;
   localparam dpg_addr_t OFS_D_DIR  = 5'h14;
   localparam dpg_addr_t OFS_E_CTRL = 5'h18;
   localparam dpg_addr_t OFS_CFG    = 5'h1c;

   // ********************************
   // reset values and fields
   // ********************************
   localparam dpg_byte_t DIR_RST     = 8'hff;
   localparam dpg_byte_t LAT_RST     = 8'h00;
   localparam dpg_byte_t E_CTRL_RST  = 8'h07;
   localparam dpg_byte_t E_CTRL_WMSK = 8'h37;
   localparam logic      CFG_RST     = 1'b1;
   localparam int unsigned E_IBF_BIT  = 7;
   localparam int unsigned E_OBF_BIT  = 6;
   localparam int unsigned E_OVF_BIT  = 5;
   localparam int unsigned E_MODE_BIT = 4;
   localparam int unsigned E_GAP_BIT  = 3;
   localparam int unsigned E_DIR_MSB  = 2;
   localparam int unsigned UNIT2_BIT  = 1;
   localparam int unsigned SYNC_DEPTH = 2;

   // ********************************
   // carriers
   // ********************************
   typedef struct packed {
      dpg_byte_t sel;
      dpg_byte_t oe;
      dpg_byte_t dat;
   } dpg_periph_t;

   typedef struct packed {
      logic sel;
      logic oe;
      logic dat;
   } dpg_unit_t;

   typedef struct packed {
      logic      oe;
      dpg_byte_t dat;
   } dpg_psp_t;

   typedef struct packed {
      dpg_byte_t dat;
      dpg_byte_t oe_n;
   } dpg_pin_t;

   typedef struct packed {
      dpg_byte_t             c_sync1;
      dpg_byte_t             c_sync2;
      dpg_byte_t             d_sync1;
      dpg_byte_t             d_sync2;
      dpg_byte_t             c_lat;
      dpg_byte_t             c_dir;
      dpg_byte_t             d_lat;
      dpg_byte_t             d_dir;
      dpg_byte_t             e_ctrl;
      logic                  cfg;
      dpg_pin_t              pin_c;
      dpg_pin_t              pin_d;
      logic [DATA_W-1:0]     rdata;
      logic                  wait_r;
   } dpg_state_t;

endpackage

/* File: dpg_port_mux.sv */
// per-pin driver selection between direction/latch and a peripheral
`timescale 1ns/1ps
`default_nettype none
module dpg_port_mux
   import dpg_pkg::*;
#(
   parameter int unsigned WIDTH = PORT_W
) (
   input  wire logic [WIDTH-1:0] dir_in,
   input  wire logic [WIDTH-1:0] lat_in,
   input  wire logic [WIDTH-1:0] sel_in,
   input  wire logic [WIDTH-1:0] oe_in,
   input  wire logic [WIDTH-1:0] dat_in,
   output var  logic [WIDTH-1:0] drv_dat_out,
   output var  logic [WIDTH-1:0] drv_oe_n_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            if (sel_in[i]) begin
               // direction register untouched by the override
               drv_oe_n_out[i] = ~oe_in[i];
               drv_dat_out[i]  = dat_in[i];
            end else begin
               drv_oe_n_out[i] = dir_in[i];
               drv_dat_out[i]  = lat_in[i];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: dpg_gpio_top.sv */
// dual 8-bit gpio ports with peripheral overrides and avalon-mm registers
//
// Contract
// - direction one floats the pin; zero drives it from the latch.
// - both ports eight bits, each pin with its own direction bit.
// - latch register has its own address and reads back the latch.
// - selected peripheral forces a third-port pin out or in.
// - overrides never alter the direction register contents.
// - reset makes every pin an input, directions all ones.
// - unit2 pin select set routes capture compare unit2 onto bit 1.
// - peripheral output enable acts only while that peripheral is selected.
// - slave-port mode bit turns the fourth port into a data port.
// - third-port bits 0 to 2 carry timer oscillator and unit1.
// - bits 3 to 5 carry serial clock, data in/out.
// - bits 6 and 7 carry usart transmit/clock and receive/data.
// - in slave-port mode fourth pin n carries data bit n.
// - pin and latch values are undefined at power-on, else kept; here every reset clears the latches to zero.
// - fifth control bit 3 reads zero; resets to 0x07.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dpg_gpio_top
   import dpg_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire dpg_addr_t         avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [DATA_W-1:0] avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output var  logic [DATA_W-1:0] avs_readdata_out,
   output var  logic              avs_waitrequest_out,
   input  wire dpg_byte_t         third_pins_in,
   output var  dpg_pin_t          third_pin_out,
   input  wire dpg_byte_t         fourth_pins_in,
   output var  dpg_pin_t          fourth_pin_out,
   input  wire dpg_periph_t       third_periph_in,
   input  wire dpg_unit_t         unit2_periph_in,
   input  wire dpg_psp_t          psp_in,
   input  wire logic              in_buffer_full_in,
   input  wire logic              out_buffer_full_in,
   input  wire logic              in_buffer_overflow_set_in,
   output var  dpg_byte_t         third_pins_sync_out,
   output var  dpg_byte_t         fourth_pins_sync_out,
   output var  logic              slave_mode_out,
   output var  logic [E_DIR_MSB:0] fifth_dir_out,
   output var  logic              unit2_pin_sel_out
);

   // ********************************
   // state and wiring
   // ********************************
   dpg_state_t  st_r;
   dpg_state_t  st_nxt;
   dpg_periph_t c_ovr;
   dpg_periph_t d_ovr;
   dpg_byte_t   c_drv_dat;
   dpg_byte_t   c_drv_oe_n;
   dpg_byte_t   d_drv_dat;
   dpg_byte_t   d_drv_oe_n;
   logic        unit2_act;
   logic        rd_acc;
   logic        wr_acc;
   logic        slave_mode;

   // ********************************
   // read decode
   // ********************************
   function automatic dpg_byte_t rd_mux(input dpg_addr_t  a,
                                        input dpg_state_t s,
                                        input logic       in_buffer_full,
                                        input logic       out_buffer_full);
      dpg_byte_t v;
      v = LAT_RST;
      case (a)
         OFS_C_PINS: v = s.c_sync2;
         OFS_C_LAT:  v = s.c_lat;
         OFS_C_DIR:  v = s.c_dir;
         OFS_D_PINS: v = s.d_sync2;
         OFS_D_LAT:  v = s.d_lat;
         OFS_D_DIR:  v = s.d_dir;
         OFS_E_CTRL: begin
            v = s.e_ctrl;
            v[E_IBF_BIT] = in_buffer_full;
            v[E_OBF_BIT] = out_buffer_full;
            v[E_GAP_BIT] = 1'b0;
         end
         OFS_CFG:    v[0] = s.cfg;
         default:    v = LAT_RST;
      endcase
      return v;
   endfunction

   // ********************************
   // peripheral override selection
   // ********************************
   // bits 0..7 each arrive with their own peripheral select; bit 1 may
   // additionally take unit2 when the pin select bit routes it here
   assign unit2_act  = unit2_periph_in.sel & st_r.cfg;
   assign slave_mode = st_r.e_ctrl[E_MODE_BIT];

   always_comb begin
      c_ovr = third_periph_in;
      if (unit2_act) begin
         c_ovr.sel[UNIT2_BIT] = 1'b1;
         c_ovr.oe[UNIT2_BIT]  = unit2_periph_in.oe;
         c_ovr.dat[UNIT2_BIT] = unit2_periph_in.dat;
      end
      // slave port: external logic decides when the data bus is driven
      d_ovr.sel = {PORT_W{slave_mode}};
      d_ovr.oe  = {PORT_W{psp_in.oe}};
      d_ovr.dat = psp_in.dat;
   end

   dpg_port_mux #(
      .WIDTH        (PORT_W)
   ) u_mux_c (
      .dir_in       (st_r.c_dir),
      .lat_in       (st_r.c_lat),
      .sel_in       (c_ovr.sel),
      .oe_in        (c_ovr.oe),
      .dat_in       (c_ovr.dat),
      .drv_dat_out  (c_drv_dat),
      .drv_oe_n_out (c_drv_oe_n)
   );

   dpg_port_mux #(
      .WIDTH        (PORT_W)
   ) u_mux_d (
      .dir_in       (st_r.d_dir),
      .lat_in       (st_r.d_lat),
      .sel_in       (d_ovr.sel),
      .oe_in        (d_ovr.oe),
      .dat_in       (d_ovr.dat),
      .drv_dat_out  (d_drv_dat),
      .drv_oe_n_out (d_drv_oe_n)
   );

   // ********************************
   // next state
   // ********************************
   always_comb begin
      st_nxt = st_r;
      // first sync stage feeds only the second one
      st_nxt.c_sync1 = third_pins_in;
      st_nxt.c_sync2 = st_r.c_sync1;
      st_nxt.d_sync1 = fourth_pins_in;
      st_nxt.d_sync2 = st_r.d_sync1;

      rd_acc = avs_read_in & st_r.wait_r;
      wr_acc = avs_write_in & ~st_r.wait_r & avs_byteenable_in[0];
      // one wait cycle per access, then a single ready cycle
      st_nxt.wait_r = ~((avs_read_in | avs_write_in) & st_r.wait_r);

      if (rd_acc) begin
         st_nxt.rdata = {{PAD_W{1'b0}},
                         rd_mux(avs_address_in, st_r,
                                in_buffer_full_in, out_buffer_full_in)};
      end

      if (wr_acc) begin
         case (avs_address_in)
            OFS_C_PINS: st_nxt.c_lat = avs_writedata_in[PORT_W-1:0];
            OFS_C_LAT:  st_nxt.c_lat = avs_writedata_in[PORT_W-1:0];
            OFS_C_DIR:  st_nxt.c_dir = avs_writedata_in[PORT_W-1:0];
            OFS_D_PINS: st_nxt.d_lat = avs_writedata_in[PORT_W-1:0];
            OFS_D_LAT:  st_nxt.d_lat = avs_writedata_in[PORT_W-1:0];
            OFS_D_DIR:  st_nxt.d_dir = avs_writedata_in[PORT_W-1:0];
            OFS_E_CTRL: st_nxt.e_ctrl = avs_writedata_in[PORT_W-1:0]
                                        & E_CTRL_WMSK;
            OFS_CFG:    st_nxt.cfg = avs_writedata_in[0];
            default:    st_nxt.cfg = st_r.cfg;
         endcase
      end

      // hardware set beats a software clear in the same cycle
      if (in_buffer_overflow_set_in) begin
         st_nxt.e_ctrl[E_OVF_BIT] = 1'b1;
      end

      st_nxt.pin_c.dat  = c_drv_dat;
      st_nxt.pin_c.oe_n = c_drv_oe_n;
      st_nxt.pin_d.dat  = d_drv_dat;
      st_nxt.pin_d.oe_n = d_drv_oe_n;
   end

   // ********************************
   // registers
   // ********************************
   // latches reset to zero: undefined is allowed at power-on and the
   // block has only one reset, so nothing else would keep them
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r.c_sync1   <= LAT_RST;
         st_r.c_sync2   <= LAT_RST;
         st_r.d_sync1   <= LAT_RST;
         st_r.d_sync2   <= LAT_RST;
         st_r.c_lat     <= LAT_RST;
         st_r.d_lat     <= LAT_RST;
         st_r.c_dir     <= DIR_RST;
         st_r.d_dir     <= DIR_RST;
         st_r.e_ctrl    <= E_CTRL_RST;
         st_r.cfg       <= CFG_RST;
         st_r.pin_c     <= {LAT_RST, DIR_RST};
         st_r.pin_d     <= {LAT_RST, DIR_RST};
         st_r.rdata     <= {DATA_W{1'b0}};
         st_r.wait_r    <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign avs_readdata_out     = st_r.rdata;
   assign avs_waitrequest_out  = st_r.wait_r;
   assign third_pin_out        = st_r.pin_c;
   assign fourth_pin_out       = st_r.pin_d;
   assign third_pins_sync_out  = st_r.c_sync2;
   assign fourth_pins_sync_out = st_r.d_sync2;
   assign slave_mode_out       = slave_mode;
   assign fifth_dir_out        = st_r.e_ctrl[E_DIR_MSB:0];
   assign unit2_pin_sel_out    = st_r.cfg;

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_req_seen;
      (avs_read_in | avs_write_in) && avs_waitrequest_out;
   endsequence

   sequence s_one_ready;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence

   chk_bus_handshake: assert property (
      s_req_seen |=> s_one_ready)
      else $error("waitrequest did not drop for exactly one cycle");

   chk_dir_hiz: assert property (
      1'b1 |=> ((st_r.pin_c.oe_n & $past(st_r.c_dir & ~c_ovr.sel))
                == $past(st_r.c_dir & ~c_ovr.sel)))
      else $error("input pin is being driven");

   chk_dir_drive: assert property (
      1'b1 |=> ((~st_r.pin_d.oe_n & $past(~st_r.d_dir & ~d_ovr.sel))
                == $past(~st_r.d_dir & ~d_ovr.sel))
            && ((st_r.pin_d.dat & $past(~d_ovr.sel))
                == ($past(st_r.d_lat) & $past(~d_ovr.sel))))
      else $error("output pin not driven from latch");

   chk_latch_rmw: assert property (
      (avs_read_in && avs_waitrequest_out && avs_address_in == OFS_C_LAT)
      |=> avs_readdata_out[PORT_W-1:0] == $past(st_r.c_lat))
      else $error("latch read returned something else");

   chk_ovr_force: assert property (
      (third_periph_in.sel[0] && third_periph_in.oe[0])
      |=> !st_r.pin_c.oe_n[0]
          && st_r.pin_c.dat[0] == $past(third_periph_in.dat[0]))
      else $error("peripheral output override ignored");

   chk_ovr_input: assert property (
      (third_periph_in.sel[PORT_W-1] && !third_periph_in.oe[PORT_W-1])
      |=> third_pin_out.oe_n[PORT_W-1])
      else $error("peripheral input override ignored");

   chk_sel_gate: assert property (
      !third_periph_in.sel[0]
      |=> third_pin_out.oe_n[0] == $past(st_r.c_dir[0])
          && third_pin_out.dat[0] == $past(st_r.c_lat[0]))
      else $error("unselected peripheral reached the pin");

   chk_dir_unchanged: assert property (
      !(avs_write_in && !avs_waitrequest_out) |=> $stable(st_r.c_dir))
      else $error("direction changed without a write");

   chk_reset_value: assert property (
      @(posedge clk_in) disable iff (1'b0)
      rst_in |-> st_r.c_dir == DIR_RST && st_r.d_dir == DIR_RST
              && third_pin_out.oe_n == DIR_RST
              && st_r.e_ctrl == E_CTRL_RST)
      else $error("reset values wrong");

   chk_unit2_pin: assert property (
      (unit2_periph_in.sel && unit2_periph_in.oe && st_r.cfg
       && !avs_write_in)
      |=> !third_pin_out.oe_n[UNIT2_BIT]
          && third_pin_out.dat[UNIT2_BIT] == $past(unit2_periph_in.dat))
      else $error("unit2 not routed to bit 1");

   chk_slave_data: assert property (
      (slave_mode && psp_in.oe)
      |=> fourth_pin_out.oe_n == LAT_RST
          && fourth_pin_out.dat == $past(psp_in.dat))
      else $error("slave port data not on fourth port");

   chk_fifth_gap: assert property (
      (avs_read_in && avs_waitrequest_out && avs_address_in == OFS_E_CTRL)
      |=> !avs_readdata_out[E_GAP_BIT])
      else $error("unimplemented bit reads one");

   chk_sync_delay: assert property (
      (!$past(rst_in) && !$past(rst_in, 2))
      |-> st_r.c_sync2 == $past(third_pins_in, 2))
      else $error("pin synchroniser depth wrong");

   chk_regs_unchanged: assert property (
      !(avs_write_in && !avs_waitrequest_out)
      |=> $stable(st_r.d_dir) && $stable(st_r.c_lat) && $stable(st_r.d_lat))
      else $error("register changed without a write");

   chk_wait_idle: assert property (
      !(avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> avs_waitrequest_out)
      else $error("waitrequest dropped with no request");

   chk_rdata_pad: assert property (
      avs_readdata_out[DATA_W-1:PORT_W] == '0)
      else $error("upper read data bits not zero");

   chk_ovf_sticky: assert property (
      in_buffer_overflow_set_in |=> st_r.e_ctrl[E_OVF_BIT])
      else $error("overflow flag not set");

   chk_port_mode: assert property (
      !slave_mode
      |=> fourth_pin_out.oe_n == $past(st_r.d_dir)
          && fourth_pin_out.dat == $past(st_r.d_lat))
      else $error("fourth port left its direction and latch");

   chk_slave_float: assert property (
      (slave_mode && !psp_in.oe) |=> fourth_pin_out.oe_n == DIR_RST)
      else $error("slave port drives while not enabled");

   chk_unit2_off: assert property (
      (!st_r.cfg && !third_periph_in.sel[UNIT2_BIT])
      |=> third_pin_out.oe_n[UNIT2_BIT] == $past(st_r.c_dir[UNIT2_BIT]))
      else $error("unit2 reached bit 1 while deselected");

   chk_pins_read: assert property (
      (avs_read_in && avs_waitrequest_out && avs_address_in == OFS_C_PINS)
      |=> avs_readdata_out[PORT_W-1:0] == $past(st_r.c_sync2))
      else $error("pin read returned something else");

endmodule
`default_nettype wire

/* File: dpg_gpio_top_tb.sv */
// self-checking testbench of the dual gpio port block
`timescale 1ns/1ps
`default_nettype none
module dpg_gpio_top_tb;
   import dpg_pkg::*;

   // ************************************
   // clock, reset and design hookup
   // ************************************
   logic              clk_in = 1'b0;
   logic              rst_in = 1'b0;
   dpg_addr_t         addr_r = '0;
   logic              rd_r   = 1'b0;
   logic              wr_r   = 1'b0;
   logic [DATA_W-1:0] wdat_r = '0;
   logic [3:0]        be_r   = 4'h0;
   logic [DATA_W-1:0] rdata;
   logic              waitreq;
   dpg_byte_t         c_pins_r = 8'h00;
   dpg_byte_t         d_pins_r = 8'h00;
   dpg_pin_t          c_pin;
   dpg_pin_t          d_pin;
   dpg_periph_t       periph_r = '0;
   dpg_unit_t         unit2_r  = '0;
   dpg_psp_t          psp_r    = '0;
   logic              ibf_r    = 1'b0;
   logic              obf_r    = 1'b0;
   logic              ovf_r    = 1'b0;
   dpg_byte_t         c_sync;
   dpg_byte_t         d_sync;
   logic              slave_mode;
   logic [E_DIR_MSB:0] fifth_dir;
   logic              unit2_sel;
   int                n_errors    = 0;
   int                comparisons = 0;
   logic [DATA_W-1:0] got;
   dpg_pin_t          pin;

   always #2.5 clk_in = ~clk_in;

   dpg_gpio_top DUT (
      .clk_in                    (clk_in),
      .rst_in                    (rst_in),
      .avs_address_in            (addr_r),
      .avs_read_in               (rd_r),
      .avs_write_in              (wr_r),
      .avs_writedata_in          (wdat_r),
      .avs_byteenable_in         (be_r),
      .avs_readdata_out          (rdata),
      .avs_waitrequest_out       (waitreq),
      .third_pins_in             (c_pins_r),
      .third_pin_out             (c_pin),
      .fourth_pins_in            (d_pins_r),
      .fourth_pin_out            (d_pin),
      .third_periph_in           (periph_r),
      .unit2_periph_in           (unit2_r),
      .psp_in                    (psp_r),
      .in_buffer_full_in         (ibf_r),
      .out_buffer_full_in        (obf_r),
      .in_buffer_overflow_set_in (ovf_r),
      .third_pins_sync_out       (c_sync),
      .fourth_pins_sync_out      (d_sync),
      .slave_mode_out            (slave_mode),
      .fifth_dir_out             (fifth_dir),
      .unit2_pin_sel_out         (unit2_sel)
   );

   // ************************************
   // shared tasks
   // ************************************
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic is_wr, input dpg_addr_t a,
                      input logic [DATA_W-1:0] d, input logic [3:0] be);
      @(posedge clk_in);
      addr_r <= a;
      wdat_r <= d;
      be_r   <= be;
      rd_r   <= ~is_wr;
      wr_r   <= is_wr;
      do @(posedge clk_in); while (waitreq !== 1'b0);
      got = rdata;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   endtask

   task automatic wr(input dpg_addr_t a, input dpg_byte_t d);
      bus(1'b1, a, {PAD_W'(0), d}, 4'h1);
   endtask

   task automatic rd(input dpg_addr_t a);
      bus(1'b0, a, '0, 4'h1);
   endtask

   // pins lag the register and override inputs by one clock
   task automatic settle();
      repeat (3) @(posedge clk_in);
      #1;
   endtask

   task automatic reset_regs();
      rd(OFS_C_DIR);  chk(got, 32'h0000_00ff);
      rd(OFS_D_DIR);  chk(got, 32'h0000_00ff);
      rd(OFS_E_CTRL); chk(got, 32'h0000_0007);
      rd(OFS_CFG);    chk(got, 32'h0000_0001);
      rd(5'h02);      chk(got, 32'h0000_0000);
      chk(c_pin.oe_n, 8'hff);
      chk(d_pin.oe_n, 8'hff);
   endtask

   // ************************************
   // ordinary port behaviour, both ports
   // ************************************
   task automatic port_io(input int p);
      dpg_addr_t b;
      b = (p == 1) ? OFS_D_PINS : OFS_C_PINS;
      wr(b + OFS_C_DIR, 8'h0f);
      wr(b + OFS_C_LAT, 8'ha5);
      settle();
      pin = (p == 1) ? d_pin : c_pin;
      chk(pin.oe_n, 8'h0f);
      chk(pin.dat & ~pin.oe_n, 8'ha0);
      if (p == 1) d_pins_r <= 8'h96;
      else c_pins_r <= 8'h96;
      repeat (5) @(posedge clk_in);
      chk((p == 1) ? d_sync : c_sync, 8'h96);
      rd(b + OFS_C_LAT); chk(got, 32'h0000_00a5);
      rd(b);             chk(got, 32'h0000_0096);
      wr(b, 8'h3c);
      rd(b + OFS_C_LAT); chk(got, 32'h0000_003c);
      rd(b);             chk(got, 32'h0000_0096);
      bus(1'b1, b + OFS_C_DIR, 32'h0000_0096, 4'h0);
      rd(b + OFS_C_DIR); chk(got, 32'h0000_000f);
      $display("test port %0d done", p);
   endtask

   // ************************************
   // main sequence
   // ************************************
   initial begin
      // a real rising edge, so the asynchronous reset acts before clocking
      rst_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      reset_regs();
      $display("test reset done");
      port_io(0);
      port_io(1);
      // selected peripherals force pins out and in, direction untouched
      wr(OFS_C_DIR, 8'h00);
      periph_r <= '{sel: 8'hfd, oe: 8'h3d, dat: 8'h5a};
      settle();
      chk(c_pin.oe_n, 8'hc0);
      chk(c_pin.dat & ~c_pin.oe_n, 8'h18);
      rd(OFS_C_DIR); chk(got, 32'h0000_0000);
      periph_r <= '{sel: 8'h00, oe: 8'hff, dat: 8'hff};
      settle();
      chk(c_pin.oe_n, 8'h00);
      chk(c_pin.dat, 8'h3c);
      $display("test overrides done");
      wr(OFS_C_DIR, 8'hff);
      unit2_r <= '{sel: 1'b1, oe: 1'b1, dat: 1'b1};
      settle();
      chk(unit2_sel, 1'b1);
      chk(c_pin.oe_n, 8'hfd);
      chk(c_pin.dat & ~c_pin.oe_n, 8'h02);
      wr(OFS_CFG, 8'h00);
      settle();
      chk(c_pin.oe_n, 8'hff);
      rd(OFS_CFG); chk(got, 32'h0000_0000);
      $display("test unit2 done");
      // slave-port mode and fifth control register
      ibf_r <= 1'b1;
      wr(OFS_E_CTRL, 8'hff);
      rd(OFS_E_CTRL); chk(got, 32'h0000_00b7);
      chk(slave_mode, 1'b1);
      chk(fifth_dir, 3'h7);
      psp_r <= '{oe: 1'b1, dat: 8'hc3};
      settle();
      chk(d_pin.oe_n, 8'h00);
      chk(d_pin.dat, 8'hc3);
      psp_r <= '{oe: 1'b0, dat: 8'hc3};
      wr(OFS_E_CTRL, 8'h10);
      settle();
      chk(d_pin.oe_n, 8'hff);
      rd(OFS_E_CTRL); chk(got, 32'h0000_0090);
      @(posedge clk_in);
      ovf_r <= 1'b1;
      @(posedge clk_in);
      ovf_r <= 1'b0;
      rd(OFS_E_CTRL); chk(got, 32'h0000_00b0);
      wr(OFS_E_CTRL, 8'h10);
      rd(OFS_E_CTRL); chk(got, 32'h0000_0090);
      $display("test slave port done");
      // second reset in mid-run returns every pin to input; unit2 is
      // dropped first since the reset selects it back onto bit 1
      ibf_r   <= 1'b0;
      unit2_r <= '0;
      rst_in  <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      reset_regs();
      $display("test second reset done");
      stop_test();
   end

   initial begin
      #50000;
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      stop_test();
   end

endmodule
`default_nettype wire
